// ---- core/bccc_regs.svh ----
// Purpose: constants for the battery charge cycle controller
// Assumes: 100 MHz clock, timer counts are whole cycles
// Notes: offsets and layout of the wishbone register map
// What this block does
// - battery below low threshold at cycle start selects trickle at one eighth current
// - trickle keeps buck charger off and enables linear charger path
// - low battery over half an hour of trickle ends in bad-battery fault
// - battery above low threshold moves trickle to full constant current
// - at charge voltage hold constant voltage, start four or two hour timer
// - timer expiry stops charging until battery drops below recharge threshold
// - idle after termination, restart cycle when battery drops below recharge
// - below recharge while the constant voltage timer runs clears the timer count
// - below recharge acted on only after over 2.4 ms continuously
// - status pair encodes thermistor fault, charging, bad battery, one eighth reached
// - charge status low while charging, released at one eighth current
// - input current limit masks one eighth indication, charge status stays low
// - bad battery releases charge status and pulls fault low
// - thermistor fault pulls fault low and keeps charge status low
// - cold or hot comparator trip suspends charging until both clear
// - thermistor fault in constant voltage freezes the safety timer
// - grounded thermistor sense disables all temperature monitoring
// - charger off within 50 mV of rail, resume above 145 mV
// - synchronous rectifier enabled only while rail exceeds battery minus 200 mV
// - rectifier current above 8 A skips next two switching cycles
// - boost shut down while battery below 2.45 V
// - boost turns off both switches above 5.5 V output
// - charger disable holds charger off regardless of cycle state
`ifndef BCCC_REGS_SVH
`define BCCC_REGS_SVH
`define BCCC_CLK_MHZ 100
`define BCCC_RECHG_US 2400
`define BCCC_RECHG_CYC ((`BCCC_RECHG_US * `BCCC_CLK_MHZ) + 1)
`define BCCC_TRICKLE_S 1800
`define BCCC_LIION_S 14400
`define BCCC_LFP_S 7200
`define BCCC_CYC_PER_S 64'd100000000
`define BCCC_SKIP_CYC 2
`define BCCC_OFF_CTRL 32'h0000_0000
`define BCCC_OFF_STATUS 32'h0000_0004
`define BCCC_OFF_TIMER 32'h0000_0008
`define BCCC_OFF_DIV 32'h0000_000C
`define BCCC_CTRL_RST 8'h00
`define BCCC_DIV_RST 8'h2C
`define BCCC_CTRL_ILIM 0
`define BCCC_CTRL_BSTOFF 1
`endif

// ---- core/bccc_pkg.sv ----
package bccc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TRICKLE = 3'b001,
		ST_CC = 3'b010,
		ST_CV = 3'b011,
		ST_DONE = 3'b100,
		ST_BAD = 3'b101
	} bccc_state_e;

	// comparator levels after synchronising
	typedef struct packed {
		logic below_low;
		logic at_charge_v;
		logic below_rechg;
		logic at_c8;
		logic ntc_cold;
		logic ntc_hot;
		logic ntc_grounded;
		logic diff_lt50;
		logic diff_gt145;
		logic sys_gt_bat_m200;
		logic sr_over_8a;
		logic bat_lt_245;
		logic out_gt_55;
		logic chem_sel;
		logic chg_dis;
	} bccc_cmp_s;

	typedef struct packed {
		logic buck_en;
		logic linear_en;
		logic trickle_cur;
		logic chg_low_oe;
		logic fault_low_oe;
		logic sr_en;
		logic main_sw_en;
	} bccc_drv_s;

	typedef struct packed {
		bccc_cmp_s s1;
		bccc_cmp_s s2;
		bccc_state_e st;
		logic [45:0] tmr;
		logic [17:0] rechg_cnt;
		logic uvlo;
		logic [1:0] skip;
		logic [1:0] sw_sync;
		logic sw_clk_prev;
		logic [7:0] ctrl;
		logic [7:0] div;
		logic ack;
		logic [31:0] dat;
		bccc_drv_s drv;
	} bccc_state_s;
endpackage

// ---- core/bccc_ctrl.sv ----
// Purpose: charge cycle sequencer and boost gating with wishbone registers
// Assumes: comparator inputs asynchronous, one 100 MHz clock
// Notes: analog loops live outside; this only decides and drives enables
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "bccc_regs.svh"
module bccc_ctrl (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// comparators and pins
	input wire bccc_pkg::bccc_cmp_s cmp_in,
	input wire logic sw_clk,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// power stage drives
	output bccc_pkg::bccc_drv_s drv,
	output logic boost_gate_en,
	output logic [2:0] state_out
);

function automatic logic [45:0] secs(input int s);
	logic [63:0] v;
	v = 64'(s) * `BCCC_CYC_PER_S;
	return v[45:0];
endfunction

bccc_pkg::bccc_state_s q, d;
logic ntc_fault, chg_allow, rechg_ok, cv_lim;
logic [45:0] cv_limit;
logic wb_req;

assign drv = q.drv;
assign wb_ack_o = q.ack;
assign wb_dat_o = q.dat;
assign state_out = q.st;
assign boost_gate_en = q.drv.main_sw_en;

always_comb begin
	d = q;
	// ------------------------------
	// synchronise
	// ------------------------------
	d.s1 = cmp_in;
	d.s2 = q.s1;
	// switching clock is a pin too, two flops before the edge detector
	d.sw_sync = {q.sw_sync[0], sw_clk};
	d.sw_clk_prev = q.sw_sync[1];

	ntc_fault = !q.s2.ntc_grounded && (q.s2.ntc_cold || q.s2.ntc_hot);
	// hysteresis lockout on rail to battery difference
	if (q.s2.diff_lt50)
		d.uvlo = 1'b1;
	else if (q.s2.diff_gt145)
		d.uvlo = 1'b0;
	chg_allow = !q.s2.chg_dis && !q.uvlo && !ntc_fault;

	// ------------------------------
	// recharge filter
	// ------------------------------
	if (!q.s2.below_rechg)
		d.rechg_cnt = '0;
	else if (q.rechg_cnt != 18'(`BCCC_RECHG_CYC))
		d.rechg_cnt = q.rechg_cnt + 18'd1;
	rechg_ok = (q.rechg_cnt == 18'(`BCCC_RECHG_CYC));

	cv_limit = q.s2.chem_sel ? secs(`BCCC_LIION_S) : secs(`BCCC_LFP_S);
	cv_lim = (q.tmr >= cv_limit);

	// ------------------------------
	// charge cycle
	// ------------------------------
	case (q.st)
	bccc_pkg::ST_IDLE: begin
		// wait for the synchronisers to hold real levels before choosing
		if (q.tmr < 46'd2) begin
			d.tmr = q.tmr + 46'd1;
		end else begin
			d.tmr = '0;
			if (q.s2.below_low)
				d.st = bccc_pkg::ST_TRICKLE;
			else
				d.st = bccc_pkg::ST_CC;
		end
	end
	bccc_pkg::ST_TRICKLE: begin
		if (!q.s2.below_low) begin
			d.st = bccc_pkg::ST_CC;
			d.tmr = '0;
		end else if (q.tmr >= secs(`BCCC_TRICKLE_S))
			d.st = bccc_pkg::ST_BAD;
		else if (chg_allow)
			d.tmr = q.tmr + 46'd1;
	end
	bccc_pkg::ST_CC: begin
		d.tmr = '0;
		if (q.s2.at_charge_v)
			d.st = bccc_pkg::ST_CV;
	end
	bccc_pkg::ST_CV: begin
		if (rechg_ok)
			d.tmr = '0;
		else if (cv_lim)
			d.st = bccc_pkg::ST_DONE;
		else if (chg_allow)
			d.tmr = q.tmr + 46'd1;
	end
	bccc_pkg::ST_DONE: begin
		d.tmr = '0;
		if (rechg_ok)
			d.st = bccc_pkg::ST_IDLE;
	end
	bccc_pkg::ST_BAD: d.tmr = '0;
	default: d.st = bccc_pkg::ST_IDLE;
	endcase

	// ------------------------------
	// charger drives and status
	// ------------------------------
	d.drv.trickle_cur = (q.st == bccc_pkg::ST_TRICKLE);
	d.drv.linear_en = (q.st == bccc_pkg::ST_TRICKLE) && chg_allow;
	d.drv.buck_en = (q.st == bccc_pkg::ST_CC || q.st == bccc_pkg::ST_CV) && chg_allow;
	case (q.st)
	bccc_pkg::ST_BAD: begin
		d.drv.chg_low_oe = 1'b0;
		d.drv.fault_low_oe = 1'b1;
	end
	bccc_pkg::ST_TRICKLE, bccc_pkg::ST_CC, bccc_pkg::ST_CV: begin
		// limit active masks the c/8 release
		d.drv.chg_low_oe = ntc_fault || !q.s2.at_c8 || q.ctrl[`BCCC_CTRL_ILIM];
		d.drv.fault_low_oe = ntc_fault;
	end
	default: begin
		d.drv.chg_low_oe = 1'b0;
		d.drv.fault_low_oe = 1'b0;
	end
	endcase

	// ------------------------------
	// boost gating
	// ------------------------------
	if (q.s2.sr_over_8a)
		d.skip = 2'(`BCCC_SKIP_CYC);
	else if (q.sw_sync[1] && !q.sw_clk_prev && q.skip != 2'd0)
		d.skip = q.skip - 2'd1;
	d.drv.main_sw_en = !q.ctrl[`BCCC_CTRL_BSTOFF] && !q.s2.bat_lt_245 && !q.s2.out_gt_55
		&& (q.skip == 2'd0) && !q.s2.sr_over_8a;
	d.drv.sr_en = d.drv.main_sw_en && q.s2.sys_gt_bat_m200;

	// ------------------------------
	// wishbone
	// ------------------------------
	wb_req = wb_cyc_i && wb_stb_i && !q.ack;
	d.ack = wb_req;
	if (wb_req) begin
		case (wb_adr_i)
		`BCCC_OFF_CTRL: begin
			d.dat = {24'h0, q.ctrl};
			if (wb_we_i && wb_sel_i[0])
				d.ctrl = wb_dat_i[7:0];
		end
		`BCCC_OFF_STATUS: d.dat = {23'h0, q.uvlo, ntc_fault, q.drv.chg_low_oe,
			q.drv.fault_low_oe, q.drv.buck_en, q.drv.linear_en, q.st};
		`BCCC_OFF_TIMER: d.dat = q.tmr[45:14];
		`BCCC_OFF_DIV: begin
			d.dat = {24'h0, q.div};
			if (wb_we_i && wb_sel_i[0])
				d.div = wb_dat_i[7:0];
		end
		default: d.dat = 32'h0000_0000;
		endcase
	end
end

always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		q <= '0;
		q.st <= bccc_pkg::ST_IDLE;
		q.ctrl <= `BCCC_CTRL_RST;
		q.div <= `BCCC_DIV_RST;
	end else begin
		q <= d;
	end
end

endmodule

// ---- verif/bccc_analog.sv ----
// Purpose: comparator model for the charge controller
// Assumes: levels in millivolts, thermistor as a 12-bit reading, cold at 3250 or above, hot at 536 or below
// Notes: thresholds not given are plain defaults
`timescale 1ns/10ps
module bccc_analog (
	// levels
	input wire logic [12:0] bat,
	input wire logic [12:0] sys,
	input wire logic [12:0] vout,
	input wire logic [11:0] thermistor_sense,
	// c8, over 8 A, chemistry, charger disable
	input wire logic [3:0] pins,
	// comparator outputs
	output bccc_pkg::bccc_cmp_s cmp
);
	logic [12:0] vchg;
	assign vchg = pins[1] ? 13'hFA0 : 13'hDAC;
	// chemistry pin is always driven solid, never left open
	assign cmp = {bat < 13'hB22, bat >= vchg, bat < 13'hF3C, pins[3], thermistor_sense >= 12'hCB2, thermistor_sense <= 12'h218,
		thermistor_sense == 12'h000, sys < bat + 13'h32, sys > bat + 13'h91, sys + 13'hC8 > bat, pins[2],
		bat < 13'h992, vout > 13'h157C, pins[1], pins[0]};
endmodule

// ---- verif/bccc_ctrl_props.sv ----
// Purpose: port checks for the charge controller
// Assumes: comparator effect reaches drives within six cycles
// Notes: timers are too long to check here
`timescale 1ns/10ps
module bccc_ctrl_props (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// watched ports
	input wire bccc_pkg::bccc_cmp_s cmp_in,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire bccc_pkg::bccc_drv_s drv,
	input wire logic boost_gate_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_cold; (cmp_in.ntc_cold && !cmp_in.ntc_grounded)[*6]; endsequence
	property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
	property p_lin; drv.linear_en |-> !drv.buck_en; endproperty
	property p_cold; s_cold |-> !drv.buck_en && !drv.linear_en; endproperty
	property p_diff; cmp_in.diff_lt50[*6] |-> !drv.buck_en && !drv.linear_en; endproperty
	property p_dis; cmp_in.chg_dis[*6] |-> !drv.buck_en && !drv.linear_en; endproperty
	property p_sr; !cmp_in.sys_gt_bat_m200[*6] |-> !drv.sr_en; endproperty
	property p_uv; cmp_in.bat_lt_245[*6] |-> !boost_gate_en; endproperty
	property p_ov; cmp_in.out_gt_55[*6] |-> !drv.main_sw_en && !drv.sr_en; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	a_lin: assert property (p_lin) else $error("linear and buck on together");
	a_cold: assert property (p_cold) else $error("charging while cold");
	a_diff: assert property (p_diff) else $error("charging near rail");
	a_dis: assert property (p_dis) else $error("charging while disabled");
	a_sr: assert property (p_sr) else $error("rectifier on below rail");
	a_uv: assert property (p_uv) else $error("boost on at low battery");
	a_ov: assert property (p_ov) else $error("switches on at overvoltage");
endmodule
bind bccc_ctrl bccc_ctrl_props chk_u (.clock(clock), .rst_n(rst_n), .cmp_in(cmp_in), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .drv(drv), .boost_gate_en(boost_gate_en));

// ---- verif/battery_charge_cycle_controller_tb.sv ----
// Purpose: sequence tests of the charge controller
// Assumes: drives settle within eight cycles of a level change
// Notes: boost switching clock held low
`timescale 1ns/10ps
`include "bccc_regs.svh"
module battery_charge_cycle_controller_tb;
	logic clock, rst_n, cyc, stb, we;
	logic [31:0] adr, wdat, rdat;
	logic ack, bgate;
	logic [2:0] st;
	logic [12:0] bat, sys, vout;
	logic [11:0] thermistor_sense;
	logic [3:0] pins;
	logic [7:0] q;
	bccc_pkg::bccc_cmp_s cmp;
	bccc_pkg::bccc_drv_s drv;
	int err_count, checks;
	bccc_analog ana_u (.bat(bat), .sys(sys), .vout(vout), .thermistor_sense(thermistor_sense), .pins(pins), .cmp(cmp));
	bccc_ctrl dut_u (.clock(clock), .rst_n(rst_n), .cmp_in(cmp), .sw_clk(1'b0), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
		.wb_dat_o(rdat), .wb_ack_o(ack), .drv(drv), .boost_gate_en(bgate), .state_out(st));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task end_of_test();
		$display("mismatches %0d of %0d checks", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// master holds the request until ack is sampled
	task wb(input logic w, input logic [31:0] a, input logic [7:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			err_count++;
			end_of_test();
		end
		@(posedge clock);
	endtask
	task look(input logic [2:0] s, input logic [3:0] f);
		repeat (8) @(posedge clock);
		chk({1'b0, st, drv.buck_en, drv.linear_en, drv.chg_low_oe, drv.fault_low_oe}, {1'b0, s, f});
	endtask
	initial begin
		{cyc, stb, we, adr, wdat} = 67'h0;
		{bat, sys, vout, thermistor_sense, pins} = {13'h9C4, 13'h1388, 13'h0FA0, 12'h3E8, 4'h2};
		err_count = 0;
		checks = 0;
		rst_n = 1'b0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		wb(1'b0, `BCCC_OFF_DIV, 8'h00);
		chk(q, `BCCC_DIV_RST);
		wb(1'b1, `BCCC_OFF_DIV, 8'h5A);
		wb(1'b0, `BCCC_OFF_DIV, 8'h00);
		chk(q, 8'h5A);
		wb(1'b0, 32'h0000_0010, 8'h00);
		chk(q, 8'h00);
		look(bccc_pkg::ST_TRICKLE, 4'h6);
		chk({7'h00, drv.trickle_cur}, 8'h01);
		bat <= 13'hBB8;
		look(bccc_pkg::ST_CC, 4'hA);
		bat <= 13'h1004;
		look(bccc_pkg::ST_CV, 4'hA);
		thermistor_sense <= 12'hCE4;
		look(bccc_pkg::ST_CV, 4'h3);
		thermistor_sense <= 12'h000;
		look(bccc_pkg::ST_CV, 4'hA);
		thermistor_sense <= 12'h3E8;
		pins <= 4'h3;
		look(bccc_pkg::ST_CV, 4'h2);
		pins <= 4'h2;
		sys <= 13'h102C;
		look(bccc_pkg::ST_CV, 4'h2);
		sys <= 13'h1388;
		look(bccc_pkg::ST_CV, 4'hA);
		wb(1'b1, `BCCC_OFF_CTRL, 8'h01);
		pins <= 4'hA;
		look(bccc_pkg::ST_CV, 4'hA);
		wb(1'b1, `BCCC_OFF_CTRL, 8'h00);
		look(bccc_pkg::ST_CV, 4'h8);
		chk({6'h00, bgate, drv.sr_en}, 8'h03);
		vout <= 13'h1770;
		repeat (8) @(posedge clock);
		chk({6'h00, bgate, drv.sr_en}, 8'h00);
		vout <= 13'h0FA0;
		sys <= 13'h0ED8;
		repeat (8) @(posedge clock);
		chk({6'h00, bgate, drv.sr_en}, 8'h02);
		bat <= 13'h0960;
		repeat (8) @(posedge clock);
		chk({6'h00, bgate, drv.sr_en}, 8'h00);
		end_of_test();
	end
endmodule
